// ---- hdl/pio_map.vh ----
/*
 * Register indices, field positions and reset values of the programmable
 * I/O port block. Byte address on APB is four times the index.
 */
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

// port data registers (index)
`define PIO_IDX_DATA0 10'h3E0
`define PIO_IDX_DATA1 10'h3E1
`define PIO_IDX_DATA2 10'h3E4
`define PIO_IDX_DATA3 10'h3E5
`define PIO_IDX_DATA4 10'h3E8
`define PIO_IDX_DATA5 10'h3E9
`define PIO_IDX_DATA6 10'h3EC
`define PIO_IDX_DATA7 10'h3ED
`define PIO_IDX_DATA8 10'h3F0
`define PIO_IDX_DATA9 10'h3F1
`define PIO_IDX_DATA10 10'h3F4

// port direction registers (index)
`define PIO_IDX_DIR0 10'h3E2
`define PIO_IDX_DIR1 10'h3E3
`define PIO_IDX_DIR2 10'h3E6
`define PIO_IDX_DIR3 10'h3E7
`define PIO_IDX_DIR4 10'h3EA
`define PIO_IDX_DIR5 10'h3EB
`define PIO_IDX_DIR6 10'h3EE
`define PIO_IDX_DIR7 10'h3EF
`define PIO_IDX_DIR8 10'h3F2
`define PIO_IDX_DIR9 10'h3F3
`define PIO_IDX_DIR10 10'h3F6

// pull-up select, port control, write protect (index)
`define PIO_IDX_PULLUP_A 10'h3FC
`define PIO_IDX_PULLUP_B 10'h3FD
`define PIO_IDX_PULLUP_C 10'h3FE
`define PIO_IDX_PORT_CTRL 10'h3FF
`define PIO_IDX_PROTECT 10'h00A

// register kinds returned by the decoder
`define PIO_KIND_DATA 3'h0
`define PIO_KIND_DIR 3'h1
`define PIO_KIND_PULLUP 3'h2
`define PIO_KIND_CTRL 3'h3
`define PIO_KIND_PROT 3'h4

// field positions
`define PIO_READBACK_BIT 0
`define PIO_DIR9_UNLOCK_BIT 2
`define PIO_NMI_LINE_BIT 5
`define PIO_NMI_PORT 8
`define PIO_EXP_MODE_BIT 0

// reset values
`define PIO_DIR_RESET 8'h00
`define PIO_PULLUP_RESET 8'h00
`define PIO_CTRL_RESET 8'h00
`define PIO_PROT_RESET 8'h00

// port 8 direction bits that exist
`define PIO_DIR8_IMPL 8'hDF
// lines that carry a pull-up at all
`define PIO_PULL_PRESENT 88'hFFFFDFFCFFFFFFFFFFFFFF
// pull-up groups that bus modes disconnect
`define PIO_PULL_BUS_OFF 22'h000DFF

`endif

// ---- hdl/pio_ports.v ----
/*
 * Programmable I/O port block: eleven 8-bit ports (88 line slots) with
 * direction, port latch, grouped pull-up select, latch read-back control
 * and a protected port 9 direction register, reached over APB.
 * Assumes pins, peripheral outputs and mode inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_ports #(
    parameter NUM_PORTS = 11,
    // lines acting as bus-control pins in expansion/microprocessor modes
    parameter [8*NUM_PORTS-1:0] BUS_PIN_MASK = 88'h0000000000FFFFFFFFFFFF
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    // processor mode: 00 single-chip, 01 expansion, 11 microprocessor
    input wire [1:0] proc_mode,
    // pins
    input wire [8*NUM_PORTS-1:0] pin_in,
    output wire [8*NUM_PORTS-1:0] pin_out,
    output wire [8*NUM_PORTS-1:0] pin_oe_n,
    output wire [8*NUM_PORTS-1:0] pullup_en,
    // peripheral outputs claiming lines
    input wire [8*NUM_PORTS-1:0] periph_out_en,
    input wire [8*NUM_PORTS-1:0] periph_out
);

    localparam NLINES = 8 * NUM_PORTS;
    localparam NGROUPS = 2 * NUM_PORTS;

    // index -> {hit, kind[2:0], port[3:0]}
    function [7:0] reg_decode;
        input [9:0] idx;
        begin
            case (idx)
                `PIO_IDX_DATA0: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h0};
                `PIO_IDX_DATA1: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h1};
                `PIO_IDX_DATA2: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h2};
                `PIO_IDX_DATA3: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h3};
                `PIO_IDX_DATA4: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h4};
                `PIO_IDX_DATA5: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h5};
                `PIO_IDX_DATA6: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h6};
                `PIO_IDX_DATA7: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h7};
                `PIO_IDX_DATA8: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h8};
                `PIO_IDX_DATA9: reg_decode = {1'b1, `PIO_KIND_DATA, 4'h9};
                `PIO_IDX_DATA10: reg_decode = {1'b1, `PIO_KIND_DATA, 4'hA};
                `PIO_IDX_DIR0: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h0};
                `PIO_IDX_DIR1: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h1};
                `PIO_IDX_DIR2: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h2};
                `PIO_IDX_DIR3: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h3};
                `PIO_IDX_DIR4: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h4};
                `PIO_IDX_DIR5: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h5};
                `PIO_IDX_DIR6: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h6};
                `PIO_IDX_DIR7: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h7};
                `PIO_IDX_DIR8: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h8};
                `PIO_IDX_DIR9: reg_decode = {1'b1, `PIO_KIND_DIR, 4'h9};
                `PIO_IDX_DIR10: reg_decode = {1'b1, `PIO_KIND_DIR, 4'hA};
                `PIO_IDX_PULLUP_A:
                    reg_decode = {1'b1, `PIO_KIND_PULLUP, 4'h0};
                `PIO_IDX_PULLUP_B:
                    reg_decode = {1'b1, `PIO_KIND_PULLUP, 4'h1};
                `PIO_IDX_PULLUP_C:
                    reg_decode = {1'b1, `PIO_KIND_PULLUP, 4'h2};
                `PIO_IDX_PORT_CTRL:
                    reg_decode = {1'b1, `PIO_KIND_CTRL, 4'h0};
                `PIO_IDX_PROTECT:
                    reg_decode = {1'b1, `PIO_KIND_PROT, 4'h0};
                default: reg_decode = 8'h00;
            endcase
        end
    endfunction

    wire [7:0] dec = reg_decode(paddr[11:2]);
    wire hit = dec[7];
    wire [2:0] kind = dec[6:4];
    wire [3:0] sel_port = dec[3:0];
    wire wr_acc = psel & penable & pwrite & hit;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire exp_mode = proc_mode[`PIO_EXP_MODE_BIT];
    wire [7:0] wdata = pwdata[7:0];

    reg [7:0] pullup_a_reg;
    reg [7:0] pullup_b_reg;
    reg [5:0] pullup_c_reg;
    reg [7:0] port_ctrl_reg;
    reg [7:0] write_protect_reg;
    reg [31:0] prdata_reg;

    wire [NLINES-1:0] dir_all;
    wire [NLINES-1:0] latch_all;
    wire [NLINES-1:0] read_all;
    wire [NGROUPS-1:0] pullup_all;
    wire latch_readback_select = port_ctrl_reg[`PIO_READBACK_BIT];
    wire dir9_write_unlock = write_protect_reg[`PIO_DIR9_UNLOCK_BIT];

    // zero wait states: read data was captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_reg;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            reg [7:0] dir_reg;
            reg [7:0] latch_reg;
            reg written_reg;
            wire [7:0] locked;
            wire [7:0] impl;
            wire wr_dir;
            wire wr_data;
            wire [7:0] pins;
            // bus-control lines frozen only in the bus modes
            assign locked = exp_mode ? BUS_PIN_MASK[8*p +: 8] : 8'h00;
            assign impl = (p == `PIO_NMI_PORT) ? `PIO_DIR8_IMPL : 8'hFF;
            assign wr_data = wr_acc && kind == `PIO_KIND_DATA
                && sel_port == p;
            assign wr_dir = wr_acc && kind == `PIO_KIND_DIR
                && sel_port == p
                && (p != 9 || dir9_write_unlock);
            assign pins = pin_in[8*p +: 8];

            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    dir_reg <= `PIO_DIR_RESET;
                end else if (wr_dir) begin
                    dir_reg <= ((dir_reg & locked) | (wdata & ~locked))
                        & impl;
                end
            end

            // no reset on purpose: latch content is unknown until written
            always @(posedge clk) begin
                if (wr_data) begin
                    latch_reg <= (latch_reg & locked) | (wdata & ~locked);
                end
            end

            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    written_reg <= 1'b0;
                end else if (wr_data) begin
                    written_reg <= 1'b1;
                end
            end

            assign dir_all[8*p +: 8] = dir_reg;
            // unwritten latch drives pin_out low; port reads still use latch_reg as it is
            assign latch_all[8*p +: 8] = written_reg ? latch_reg : 8'h00;
            assign read_all[8*p +: 8] =
                (p == 1 && latch_readback_select) ? latch_reg
                : ((dir_reg & latch_reg) | (~dir_reg & pins));
        end
    endgenerate

    genvar b;
    generate
        for (b = 0; b < NLINES; b = b + 1) begin : g_line
            wire drive = periph_out_en[b] | dir_all[b];
            // line without a direction bit never drives
            wire real_line = (b != 8*`PIO_NMI_PORT + `PIO_NMI_LINE_BIT);
            assign pin_oe_n[b] = ~(drive & real_line);
            assign pin_out[b] = periph_out_en[b] ? periph_out[b]
                : latch_all[b];
        end
    endgenerate

    assign pullup_all = {pullup_c_reg, pullup_b_reg, pullup_a_reg};

    // sized copies so each group picks its own bits, no wide shifts
    localparam [NGROUPS-1:0] PULL_BUS_OFF = `PIO_PULL_BUS_OFF;
    localparam [NLINES-1:0] PULL_PRESENT = `PIO_PULL_PRESENT;

    genvar g;
    generate
        for (g = 0; g < NGROUPS; g = g + 1) begin : g_pull
            wire grp_on = pullup_all[g] & ~(exp_mode & PULL_BUS_OFF[g]);
            assign pullup_en[4*g +: 4] = {4{grp_on}} & ~dir_all[4*g +: 4]
                & PULL_PRESENT[4*g +: 4];
        end
    endgenerate

    // control registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pullup_a_reg <= `PIO_PULLUP_RESET;
            pullup_b_reg <= `PIO_PULLUP_RESET;
            pullup_c_reg <= 6'h00;
            port_ctrl_reg <= `PIO_CTRL_RESET;
        end else if (wr_acc && kind == `PIO_KIND_PULLUP) begin
            case (sel_port)
                4'h0: pullup_a_reg <= wdata;
                4'h1: pullup_b_reg <= wdata;
                default: pullup_c_reg <= wdata[5:0];
            endcase
        end else if (wr_acc && kind == `PIO_KIND_CTRL) begin
            port_ctrl_reg <= wdata;
        end
    end

    // unlock lasts for exactly one following write of any register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_protect_reg <= `PIO_PROT_RESET;
        end else if (wr_acc && kind == `PIO_KIND_PROT) begin
            write_protect_reg <= wdata;
        end else if (psel && penable && pwrite) begin
            write_protect_reg[`PIO_DIR9_UNLOCK_BIT] <= 1'b0;
        end
    end

    // read data sampled in the setup cycle so prdata comes from a flop
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        case (kind)
            `PIO_KIND_DATA: rd_mux = read_all[8*sel_port +: 8];
            `PIO_KIND_DIR: rd_mux = dir_all[8*sel_port +: 8];
            `PIO_KIND_PULLUP: begin
                case (sel_port)
                    4'h0: rd_mux = pullup_a_reg;
                    4'h1: rd_mux = pullup_b_reg;
                    default: rd_mux = {2'b00, pullup_c_reg};
                endcase
            end
            `PIO_KIND_CTRL: rd_mux = port_ctrl_reg;
            `PIO_KIND_PROT: rd_mux = write_protect_reg;
            default: rd_mux = 8'h00;
        endcase
        if (!hit || sel_port >= NUM_PORTS) begin
            rd_mux = 8'h00;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_reg <= {24'h000000, rd_mux};
        end
    end

endmodule // pio_ports

// ---- bench/pio_ports_assertions.sv ----
/* Checker for the I/O port block: APB answer, pin drive and pull-ups.
   Assumes it is bound to pio_ports and sees only its ports. */
`timescale 1ns/1ps
module pio_checker #(
    parameter NUM_PORTS = 11,
    parameter [8*NUM_PORTS-1:0] BUS_PIN_MASK = 88'h0
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // mode and pins
    input wire [1:0] proc_mode,
    input wire [8*NUM_PORTS-1:0] pin_out,
    input wire [8*NUM_PORTS-1:0] pin_oe_n,
    input wire [8*NUM_PORTS-1:0] pullup_en,
    input wire [8*NUM_PORTS-1:0] periph_out_en,
    input wire [8*NUM_PORTS-1:0] periph_out
);
    localparam W = 8*NUM_PORTS;
    // nmi line never drives, so peripherals cannot claim it
    localparam [W-1:0] NO_NMI = ~({{(W-1){1'h0}}, 1'h1} << 69);
    localparam [W-1:0] BUS_PU = 48'hFF0F_FFFF_FFFF;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    nmi_input_only_a: assert property (
        pin_oe_n[69] && !pullup_en[69])
        else $error("nmi line driven or pulled up");
    reset_all_input_a: assert property (
        $rose(reset_n) |-> &(pin_oe_n | periph_out_en))
        else $error("line driven after reset");
    periph_drives_a: assert property (
        (periph_out_en & NO_NMI & (pin_oe_n | (pin_out ^ periph_out))) == 0)
        else $error("peripheral output not driven");
    pullup_inputs_a: assert property (
        (pullup_en & ~pin_oe_n & ~periph_out_en) == 0)
        else $error("pull-up on an output line");
    bus_no_pullup_a: assert property (
        proc_mode[0] |-> (pullup_en & BUS_PU) == 0)
        else $error("pull-up on bus line in bus mode");
    bus_dir_frozen_a: assert property (
        proc_mode[0] && $past(proc_mode[0]) && $stable(periph_out_en)
        |-> $stable(pin_oe_n & BUS_PIN_MASK))
        else $error("bus pin direction changed");
    bus_latch_frozen_a: assert property (
        proc_mode[0] && $past(proc_mode[0]) && $stable(periph_out_en)
        && $stable(periph_out) |-> $stable(pin_out & BUS_PIN_MASK))
        else $error("bus pin latch changed");
endmodule // pio_checker

bind pio_ports pio_checker #(.NUM_PORTS(NUM_PORTS),
    .BUS_PIN_MASK(BUS_PIN_MASK)) chk_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .proc_mode(proc_mode), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .periph_out_en(periph_out_en),
    .periph_out(periph_out));

// ---- bench/pio_pin_model.sv ----
/* External pins and devices on the port lines.
   Assumes the bench chooses which lines an outside device drives. */
`timescale 1ns/1ps
module pio_pin_model #(
    parameter W = 88
) (
    // clock
    input wire clk,
    // from the block
    input wire [W-1:0] pin_out,
    input wire [W-1:0] pin_oe_n,
    input wire [W-1:0] pullup_en,
    // outside drivers
    input wire [W-1:0] ext_en,
    input wire [W-1:0] ext_val,
    // to the block
    output wire [W-1:0] pin_in
);
    // undriven lines without pull-up wander, so stale levels show up
    reg [W-1:0] flt = {W{1'h0}};
    always @(posedge clk) begin
        flt <= ~flt;
    end
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & (pullup_en | flt));
endmodule // pio_pin_model

// ---- bench/tb_programmable_io_ports.sv ----
/* Bench for pio_ports: APB tasks and directed port scenarios.
   Assumes pio_map.vh is on the include path. */
`timescale 1ns/1ps
`include "pio_map.vh"
module tb_programmable_io_ports;
    reg clk, reset_n, psel, penable, pwrite, err;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    reg [1:0] proc_mode;
    reg [87:0] pe, pv, ext_en, ext_val;
    reg [7:0] rd;
    wire pready, pslverr;
    wire [31:0] prdata;
    wire [87:0] pin_in, pin_out, pin_oe_n, pullup_en;
    integer miscompares, total_checks, i;

    pio_ports uut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .proc_mode(proc_mode), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .periph_out_en(pe),
        .periph_out(pv));
    pio_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    function [9:0] ix(input integer p, input [9:0] b);
        ix = b + 10'(p / 2 * 4 + p % 2);
    endfunction

    task chk(input string n, input [7:0] s, input [7:0] e);
        total_checks = total_checks + 1;
        if (s !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task apb(input w, input [9:0] a, input [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input [9:0] a, input [7:0] d);
        apb(1'h1, a, d);
    endtask

    task rdc(input [9:0] a, input [7:0] e);
        apb(1'h0, a, 8'h0);
        chk("register", rd, e);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        miscompares = miscompares + 1;
        give_verdict;
    end

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, proc_mode} = 0;
        {pe, pv, ext_en, ext_val} = 0;
        miscompares = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        @(negedge clk);
        chk("all input", {7'h0, &pin_oe_n}, 8'h01);
        for (i = 0; i < 11; i = i + 1)
            rdc(ix(i, `PIO_IDX_DIR0), 8'h00);
        wr(`PIO_IDX_DATA6, 8'hA5);
        wr(`PIO_IDX_DIR6, 8'hFF);
        @(negedge clk);
        chk("p6 out", pin_out[55:48], 8'hA5);
        chk("p6 oe", pin_oe_n[55:48], 8'h00);
        rdc(`PIO_IDX_DATA6, 8'hA5);
        wr(`PIO_IDX_DIR6, 8'h0F);
        ext_en[55:48] <= 8'hF0;
        ext_val[55:48] <= 8'hC0;
        rdc(`PIO_IDX_DATA6, 8'hC5);
        wr(`PIO_IDX_DATA6, 8'h3C);
        rdc(`PIO_IDX_DATA6, 8'hCC);
        wr(`PIO_IDX_PULLUP_B, 8'h30);
        ext_en[55:48] <= 8'h00;
        @(negedge clk);
        chk("p6 pull", pullup_en[55:48], 8'hF0);
        rdc(`PIO_IDX_DATA6, 8'hFC);
        wr(`PIO_IDX_DIR1, 8'h00);
        wr(`PIO_IDX_DATA1, 8'h5A);
        ext_en[15:8] <= 8'hFF;
        ext_val[15:8] <= 8'h33;
        rdc(`PIO_IDX_DATA1, 8'h33);
        wr(`PIO_IDX_PORT_CTRL, 8'h01);
        rdc(`PIO_IDX_DATA1, 8'h5A);
        wr(`PIO_IDX_PORT_CTRL, 8'h00);
        rdc(`PIO_IDX_DATA1, 8'h33);
        wr(`PIO_IDX_DATA0, 8'h11);
        proc_mode <= 2'h1;
        wr(`PIO_IDX_PULLUP_A, 8'hFF);
        @(negedge clk);
        chk("p0 pull", pullup_en[7:0], 8'h00);
        rdc(`PIO_IDX_PULLUP_A, 8'hFF);
        proc_mode <= 2'h0;
        @(negedge clk);
        chk("p0 pull", pullup_en[7:0], 8'hFF);
        @(posedge clk);
        proc_mode <= 2'h3;
        wr(`PIO_IDX_DIR0, 8'hFF);
        wr(`PIO_IDX_DATA0, 8'h77);
        rdc(`PIO_IDX_DIR0, 8'h00);
        proc_mode <= 2'h0;
        wr(`PIO_IDX_DIR0, 8'hFF);
        rdc(`PIO_IDX_DATA0, 8'h11);
        wr(`PIO_IDX_DIR8, 8'hFF);
        rdc(`PIO_IDX_DIR8, 8'hDF);
        for (i = 0; i < 2; i = i + 1) begin
            ext_en[69] <= 1'h1;
            ext_val[69] <= i[0];
            apb(1'h0, `PIO_IDX_DATA8, 8'h0);
            chk("nmi", rd & 8'h20, {2'h0, i[0], 5'h0});
        end
        wr(`PIO_IDX_DIR9, 8'hFF);
        rdc(`PIO_IDX_DIR9, 8'h00);
        wr(`PIO_IDX_PROTECT, 8'h04);
        wr(`PIO_IDX_DIR9, 8'h3C);
        rdc(`PIO_IDX_DIR9, 8'h3C);
        wr(`PIO_IDX_DIR9, 8'hFF);
        wr(`PIO_IDX_PROTECT, 8'h04);
        wr(`PIO_IDX_DATA9, 8'h00);
        wr(`PIO_IDX_DIR9, 8'hFF);
        rdc(`PIO_IDX_DIR9, 8'h3C);
        apb(1'h0, 10'h100, 8'h0);
        chk("unmapped", {err, rd[6:0]}, 8'h80);
        pe[80] <= 1'h1;
        pv[80] <= 1'h1;
        @(negedge clk);
        chk("periph", {6'h0, pin_oe_n[80], pin_out[80]}, 8'h01);
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        rdc(`PIO_IDX_DIR9, 8'h00);
        give_verdict;
    end
endmodule // tb_programmable_io_ports
